// ==== core/rx_slot_map_pkg.sv ====
// constants shared by the secondary serial port receive slot mapper
// assumes an 8-bit register port and a sampled bit clock on the core clock
`default_nettype none

package rx_slot_map_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] RX_MSB_DELAY_ADDR = 8'h26;
  localparam logic [7:0] RX_CHANNEL_PIN_SELECT_ADDR = 8'h27;
  localparam logic [7:0] RX_CHANNEL_ONE_MAP_ADDR = 8'h28;
  localparam logic [7:0] RX_CHANNEL_TWO_MAP_ADDR = 8'h29;
  localparam logic [7:0] RX_MSB_DELAY_RESET = 8'h00;
  localparam logic [7:0] RX_CHANNEL_PIN_SELECT_RESET = 8'h00;
  localparam logic [7:0] RX_CHANNEL_ONE_MAP_RESET = 8'h00;
  localparam logic [7:0] RX_CHANNEL_TWO_MAP_RESET = 8'h01;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MAP_ENABLE_BIT = 5;
  localparam int MAP_SLOT_MSB = 4;
  localparam int DELAY_MSB = 4;
  localparam int SAMPLE_BITS = 32;

  // ****************************************
  // frame formats and word lengths
  // ****************************************
  typedef enum logic [1:0] {
    FMT_TDM = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LEFT_JUSTIFIED = 2'b10
  } format_e;

  localparam logic [4:0] TDM_LAST_SLOT = 5'h1F;
  localparam logic [4:0] HALF_LAST_SLOT = 5'h0F;

  function automatic logic [5:0] word_bits(input logic [1:0] sel);
    case (sel)
      2'b00: word_bits = 6'd16;
      2'b01: word_bits = 6'd20;
      2'b10: word_bits = 6'd24;
      default: word_bits = 6'd32;
    endcase
  endfunction : word_bits

endpackage : rx_slot_map_pkg

`default_nettype wire

// ==== core/rx_slot_capture.sv ====
// one receive channel: picks its data pin, waits for its slot, assembles the sample
// assumes take and last_bit come from the frame counter of the parent on one clock
`default_nettype none

module rx_slot_capture
  import rx_slot_map_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic rstn_i, // async reset, active low
  input wire logic take_i, // bit clock rise inside an active frame
  input wire logic last_bit_i, // this bit closes its slot
  input wire logic [4:0] cur_slot_i, // slot of the bit being taken
  input wire logic data_in_i, // first data pin
  input wire logic data_in_secondary_i, // second data pin
  input wire logic pin_pick_i, // 0 first pin, 1 second pin
  input wire logic enable_i, // channel enable
  input wire logic [4:0] slot_i, // assigned slot
  output logic [SAMPLE_BITS-1:0] sample_o, // assembled sample, right aligned
  output logic sample_valid_o // one-cycle new sample strobe
);

  logic [SAMPLE_BITS-1:0] shift;
  logic bit_in;
  logic hit;

  assign bit_in = pin_pick_i ? data_in_secondary_i : data_in_i;
  assign hit = take_i && enable_i && (cur_slot_i == slot_i);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      shift <= '0;
    end
    else if (hit)
    begin
      shift <= last_bit_i ? '0 : {shift[SAMPLE_BITS-2:0], bit_in};
    end
  end

  // disabled channel never touches the dac sample
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sample_o <= '0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= hit && last_bit_i;
      if (hit && last_bit_i)
      begin
        sample_o <= {shift[SAMPLE_BITS-2:0], bit_in};
      end
    end
  end

endmodule : rx_slot_capture

`default_nettype wire

// ==== core/secondary_serial_rx_slot_map.sv ====
// receive slot mapping of the secondary serial port, channels 1 and 2 to the dac
// assumes bit clock, frame sync and data pins already synchronous to the core clock
//
// Behaviour
// - pin-select bit n-1 picks first (0) or second (1) data pin for channel n
// - channel 1 map bit 5: 0 disables, 1 feeds dac channel 1
// - channel 2 map bit 5: 0 disables, 1 feeds dac channel 2
// - map bits 4:0 hold slot number; tdm captures that slot 0 to 31
// - i2s and left-justified: 0-15 left slots, 16-31 right slots 0-15
// - reset: ch1 off slot 0, ch2 off slot 1, all pins first
// - map bits 7:6 read zero; software writes them only as zero
// - slot 0 msb delayed by 0 to 31 bit clocks, both pins
`default_nettype none

module secondary_serial_rx_slot_map
  import rx_slot_map_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock, 100 MHz
  input wire logic RSTN_I, // async reset, active low
  input wire logic [7:0] REG_ADDR_I, // register address
  input wire logic [7:0] REG_WDATA_I, // register write data
  input wire logic REG_WR_I, // register write strobe
  input wire logic REG_RD_I, // register read strobe
  input wire logic [1:0] FORMAT_I, // frame format select
  input wire logic [1:0] WORD_LEN_I, // 16, 20, 24 or 32 bits
  input wire logic BIT_CLK_I, // serial bit clock, sampled
  input wire logic FRAME_SYNC_I, // frame sync
  input wire logic DATA_IN_I, // first data input pin
  input wire logic DATA_IN_SECONDARY_I, // second data input pin
  output logic [7:0] REG_RDATA_O, // register read data
  output logic [7:0] PIN_PICK_O, // per channel pin select
  output logic [31:0] DAC_CH_ONE_SAMPLE_O, // dac channel 1 sample
  output logic DAC_CH_ONE_VALID_O, // dac channel 1 sample strobe
  output logic [31:0] DAC_CH_TWO_SAMPLE_O, // dac channel 2 sample
  output logic DAC_CH_TWO_VALID_O // dac channel 2 sample strobe
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] rx_channel_pin_select;
  logic [4:0] rx_msb_delay;
  logic rx_ch_one_enable;
  logic [4:0] rx_ch_one_slot;
  logic rx_ch_two_enable;
  logic [4:0] rx_ch_two_slot;

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rx_channel_pin_select <= RX_CHANNEL_PIN_SELECT_RESET;
      rx_msb_delay <= RX_MSB_DELAY_RESET[DELAY_MSB:0];
      rx_ch_one_enable <= RX_CHANNEL_ONE_MAP_RESET[MAP_ENABLE_BIT];
      rx_ch_one_slot <= RX_CHANNEL_ONE_MAP_RESET[MAP_SLOT_MSB:0];
      rx_ch_two_enable <= RX_CHANNEL_TWO_MAP_RESET[MAP_ENABLE_BIT];
      rx_ch_two_slot <= RX_CHANNEL_TWO_MAP_RESET[MAP_SLOT_MSB:0];
    end
    else if (REG_WR_I)
    begin
      // bits 7:6 of the map registers have no storage
      case (REG_ADDR_I)
        RX_MSB_DELAY_ADDR: rx_msb_delay <= REG_WDATA_I[DELAY_MSB:0];
        RX_CHANNEL_PIN_SELECT_ADDR: rx_channel_pin_select <= REG_WDATA_I;
        RX_CHANNEL_ONE_MAP_ADDR:
        begin
          rx_ch_one_enable <= REG_WDATA_I[MAP_ENABLE_BIT];
          rx_ch_one_slot <= REG_WDATA_I[MAP_SLOT_MSB:0];
        end
        RX_CHANNEL_TWO_MAP_ADDR:
        begin
          rx_ch_two_enable <= REG_WDATA_I[MAP_ENABLE_BIT];
          rx_ch_two_slot <= REG_WDATA_I[MAP_SLOT_MSB:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      REG_RDATA_O <= 8'h00;
    end
    else if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        RX_MSB_DELAY_ADDR: REG_RDATA_O <= {3'b000, rx_msb_delay};
        RX_CHANNEL_PIN_SELECT_ADDR: REG_RDATA_O <= rx_channel_pin_select;
        RX_CHANNEL_ONE_MAP_ADDR: REG_RDATA_O <= {2'b00, rx_ch_one_enable, rx_ch_one_slot};
        RX_CHANNEL_TWO_MAP_ADDR: REG_RDATA_O <= {2'b00, rx_ch_two_enable, rx_ch_two_slot};
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      PIN_PICK_O <= RX_CHANNEL_PIN_SELECT_RESET;
    end
    else
    begin
      PIN_PICK_O <= rx_channel_pin_select;
    end
  end

  // ****************************************
  // frame position tracking
  // ****************************************
  logic bclk_prev;
  logic frame_sync_prev;
  logic edge_armed;
  logic [5:0] skip;
  logic [5:0] bit_idx;
  logic [4:0] slot_idx;
  logic half_right;
  logic active;

  logic bclk_rise;
  logic frame_evt;
  logic is_tdm;
  logic is_i2s;
  logic next_half;
  logic [5:0] start_skip;
  logic [5:0] eff_skip;
  logic [5:0] eff_bit;
  logic [4:0] eff_slot;
  logic eff_half;
  logic eff_active;
  logic take;
  logic last_bit;
  logic [4:0] last_slot;
  logic [4:0] cur_slot;

  assign is_tdm = (FORMAT_I != FMT_I2S) && (FORMAT_I != FMT_LEFT_JUSTIFIED);
  assign is_i2s = (FORMAT_I == FMT_I2S);
  // first cycle after reset only learns the pin levels, so a high bit clock is no false rise
  assign bclk_rise = edge_armed && BIT_CLK_I && !bclk_prev;
  // tdm starts on the sync rise; the two-half formats restart on every sync edge
  assign frame_evt = bclk_rise && (is_tdm ? (FRAME_SYNC_I && !frame_sync_prev)
                                          : (FRAME_SYNC_I != frame_sync_prev));
  assign next_half = is_i2s ? FRAME_SYNC_I : (!is_tdm && !FRAME_SYNC_I);
  // i2s carries its msb one bit clock after the sync edge
  assign start_skip = {1'b0, rx_msb_delay} + {5'b00000, is_i2s};
  assign eff_skip = frame_evt ? start_skip : skip;
  assign eff_bit = frame_evt ? 6'd0 : bit_idx;
  assign eff_slot = frame_evt ? 5'd0 : slot_idx;
  assign eff_half = frame_evt ? next_half : half_right;
  assign eff_active = frame_evt || active;
  assign take = bclk_rise && eff_active && (eff_skip == 6'd0);
  assign last_bit = (eff_bit == word_bits(WORD_LEN_I) - 6'd1);
  assign last_slot = is_tdm ? TDM_LAST_SLOT : HALF_LAST_SLOT;
  assign cur_slot = is_tdm ? eff_slot : {eff_half, eff_slot[3:0]};

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      bclk_prev <= 1'b0;
      frame_sync_prev <= 1'b0;
      edge_armed <= 1'b0;
    end
    else
    begin
      bclk_prev <= BIT_CLK_I;
      edge_armed <= 1'b1;
      if (bclk_rise || !edge_armed)
      begin
        frame_sync_prev <= FRAME_SYNC_I;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      skip <= 6'd0;
      bit_idx <= 6'd0;
      slot_idx <= 5'd0;
      half_right <= 1'b0;
      active <= 1'b0;
    end
    else if (bclk_rise)
    begin
      skip <= (eff_skip != 6'd0) ? eff_skip - 6'd1 : 6'd0;
      half_right <= eff_half;
      slot_idx <= eff_slot;
      bit_idx <= eff_bit;
      active <= eff_active;
      if (take)
      begin
        bit_idx <= last_bit ? 6'd0 : eff_bit + 6'd1;
        if (last_bit)
        begin
          // stop after the last slot so a long frame cannot wrap onto slot 0
          slot_idx <= eff_slot + 5'd1;
          active <= (eff_slot != last_slot);
        end
      end
    end
  end

  // ****************************************
  // channel capture
  // ****************************************
  rx_slot_capture u_ch_one (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .take_i(take),
    .last_bit_i(last_bit),
    .cur_slot_i(cur_slot),
    .data_in_i(DATA_IN_I),
    .data_in_secondary_i(DATA_IN_SECONDARY_I),
    .pin_pick_i(rx_channel_pin_select[0]),
    .enable_i(rx_ch_one_enable),
    .slot_i(rx_ch_one_slot),
    .sample_o(DAC_CH_ONE_SAMPLE_O),
    .sample_valid_o(DAC_CH_ONE_VALID_O)
  );

  rx_slot_capture u_ch_two (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .take_i(take),
    .last_bit_i(last_bit),
    .cur_slot_i(cur_slot),
    .data_in_i(DATA_IN_I),
    .data_in_secondary_i(DATA_IN_SECONDARY_I),
    .pin_pick_i(rx_channel_pin_select[1]),
    .enable_i(rx_ch_two_enable),
    .slot_i(rx_ch_two_slot),
    .sample_o(DAC_CH_TWO_SAMPLE_O),
    .sample_valid_o(DAC_CH_TWO_VALID_O)
  );

endmodule : secondary_serial_rx_slot_map

`default_nettype wire

// ==== testbench/rx_slot_map_checker.sv ====
// assertions on the slot mapper top ports
// assumes the bind below onto the design top
`default_nettype none

module rx_slot_map_checker (
  input wire logic CORE_CLK_I, // clock
  input wire logic RSTN_I, // reset
  input wire logic [7:0] REG_ADDR_I, // addr
  input wire logic [7:0] REG_WDATA_I, // wdata
  input wire logic REG_WR_I, // write
  input wire logic REG_RD_I, // read
  input wire logic [7:0] REG_RDATA_O, // rdata
  input wire logic [7:0] PIN_PICK_O, // picks
  input wire logic DAC_CH_ONE_VALID_O, // ch1 strobe
  input wire logic DAC_CH_TWO_VALID_O // ch2 strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // register mirrors
  // ****
  logic [5:0] m1;
  logic [5:0] m2;
  logic [7:0] pk;
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      m1 <= 6'h00;
      m2 <= 6'h01;
      pk <= 8'h00;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == 8'h27)
        pk <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h28)
        m1 <= REG_WDATA_I[5:0];
      if (REG_ADDR_I == 8'h29)
        m2 <= REG_WDATA_I[5:0];
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // ****
  // properties
  // ****
  a_ch_one_off: assert property (!m1[5] && !$past(m1[5]) |-> !DAC_CH_ONE_VALID_O)
    else $error("ch1 strobe while off");
  a_ch_two_off: assert property (!m2[5] && !$past(m2[5]) |-> !DAC_CH_TWO_VALID_O)
    else $error("ch2 strobe while off");
  a_one_map_read: assert property (REG_RD_I && REG_ADDR_I == 8'h28
    |=> REG_RDATA_O == {2'b00, $past(m1)}) else $error("ch1 map read");
  a_two_map_read: assert property (REG_RD_I && REG_ADDR_I == 8'h29
    |=> REG_RDATA_O == {2'b00, $past(m2)}) else $error("ch2 map read");
  a_pick_read: assert property (REG_RD_I && REG_ADDR_I == 8'h27
    |=> REG_RDATA_O == $past(pk)) else $error("pick read");
  a_unmapped_read: assert property (REG_RD_I && (REG_ADDR_I < 8'h26 || REG_ADDR_I > 8'h29)
    |=> REG_RDATA_O == 8'h00) else $error("unmapped read");
  a_read_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved");
  a_pick_copy: assert property (PIN_PICK_O == $past(pk))
    else $error("pick output");
  a_one_pulse: assert property (DAC_CH_ONE_VALID_O |=> !DAC_CH_ONE_VALID_O)
    else $error("ch1 strobe long");
endmodule : rx_slot_map_checker

bind secondary_serial_rx_slot_map rx_slot_map_checker chk_inst (.*);

`default_nettype wire

// ==== testbench/serial_host_model.sv ====
// host driving frames onto both receive data pins
// assumes send is called while the bit clock stands still
`default_nettype none

module serial_host_model
  import rx_slot_map_pkg::*;
(
  input wire logic clk_i, // core clock
  output logic bclk_o, // bit clock
  output logic sync_o, // frame sync
  output logic [1:0] dat_o // pins, second in bit 1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'b0;
  initial
  begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    dat_o = 2'b00;
  end
  // released pins must not keep their last value
  always @(posedge clk_i)
    if (!busy)
      dat_o <= #1 ~dat_o;
  task automatic put(input logic s, input logic [1:0] d);
    @(posedge clk_i);
    #1;
    bclk_o = 1'b0;
    sync_o = s;
    dat_o = d;
    @(posedge clk_i);
    #1;
    bclk_o = 1'b1;
    @(posedge clk_i);
  endtask : put
  task automatic send(input logic [1:0] f, input int wl, input int ofs, input logic [63:0] b);
    int skip;
    int nh;
    int s;
    int n;
    busy = 1'b1;
    skip = ofs + (f == FMT_I2S);
    nh = (f == FMT_I2S || f == FMT_LEFT_JUSTIFIED) ? 2 : 1;
    // lead-in bit gives the sync a level to change from
    put(f == FMT_I2S, ~dat_o);
    for (int h = 0; h < nh; h++)
      for (int k = 0; k < skip + wl * 32 / nh; k++)
      begin
        s = h * 16 + (k - skip) / wl;
        n = wl - 1 - (k - skip) % wl;
        put(nh == 1 ? k == 0 : 1'(h) ^ (f == FMT_LEFT_JUSTIFIED),
          k < skip ? 2'(k) : {b[32 + n] ^ 1'(s >> n), b[n] ^ 1'(s >> n)});
      end
    busy = 1'b0;
  endtask : send
endmodule : serial_host_model

`default_nettype wire

// ==== testbench/tb_secondary_serial_rx_slot_map.sv ====
// self-checking bench for the receive slot mapper
// assumes the checker binds itself and the host model makes frames
`default_nettype none

module tb_secondary_serial_rx_slot_map
  import rx_slot_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK_I;
  logic RSTN_I = 1'b0;
  logic [7:0] REG_ADDR_I = 8'h00;
  logic [7:0] REG_WDATA_I = 8'h00;
  logic REG_WR_I = 1'b0;
  logic REG_RD_I = 1'b0;
  logic [1:0] FORMAT_I = 2'b00;
  logic [1:0] WORD_LEN_I = 2'b00;
  wire logic BIT_CLK_I;
  wire logic FRAME_SYNC_I;
  wire logic DATA_IN_I;
  wire logic DATA_IN_SECONDARY_I;
  logic [7:0] REG_RDATA_O;
  logic [7:0] PIN_PICK_O;
  logic [31:0] DAC_CH_ONE_SAMPLE_O;
  logic DAC_CH_ONE_VALID_O;
  logic [31:0] DAC_CH_TWO_SAMPLE_O;
  logic DAC_CH_TWO_VALID_O;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 32'haebb_c5dc;
  logic rd_pend = 1'b0;
  logic [7:0] rq [$];
  logic [31:0] q1 [$];
  logic [31:0] q2 [$];
  // format, word length, delay, map one, map two, spare, picks; format 11 runs as tdm
  logic [34:0] tab [4] = '{{2'b00, 2'b00, 5'h00, 8'h20, 8'h21, 2'b00, 8'h02},
    {2'b11, 2'b11, 5'h1f, 8'h3f, 8'h05, 2'b00, 8'hfd},
    {2'b01, 2'b10, 5'h03, 8'h2f, 8'h30, 2'b00, 8'h02},
    {2'b10, 2'b01, 5'h00, 8'h3f, 8'h20, 2'b00, 8'h01}};
  secondary_serial_rx_slot_map dut (.*);
  serial_host_model host (.clk_i(CORE_CLK_I), .bclk_o(BIT_CLK_I), .sync_o(FRAME_SYNC_I),
    .dat_o({DATA_IN_SECONDARY_I, DATA_IN_I}));
  initial
  begin
    CORE_CLK_I = 1'b0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    #1;
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = w;
    REG_RD_I = !w;
    if (!w)
      rq.push_back(d);
    @(posedge CORE_CLK_I);
    #1;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
  endtask : acc
  always @(posedge CORE_CLK_I)
  begin
    if (rd_pend)
      chk(32'(REG_RDATA_O), 32'(rq.pop_front()));
    if (DAC_CH_ONE_VALID_O === 1'b1)
      chk(DAC_CH_ONE_SAMPLE_O, q1.size() > 0 ? q1.pop_front() : 'x);
    if (DAC_CH_TWO_VALID_O === 1'b1)
      chk(DAC_CH_TWO_SAMPLE_O, q2.size() > 0 ? q2.pop_front() : 'x);
    rd_pend <= REG_RD_I;
  end
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    logic [34:0] t;
    logic [63:0] b;
    logic [7:0] v;
    logic [31:0] last2;
    logic [31:0] mask;
    int wl;
    repeat (2) @(posedge CORE_CLK_I);
    #1;
    RSTN_I = 1'b1;
    foreach (tab[i])
      acc(1'b0, 8'h26 + 8'(i), i == 3 ? 8'h01 : 8'h00);
    // software keeps the reserved map bits at zero
    acc(1'b1, 8'h28, 8'h3f);
    acc(1'b0, 8'h28, 8'h3f);
    acc(1'b1, 8'h29, 8'h1a);
    acc(1'b0, 8'h29, 8'h1a);
    acc(1'b1, 8'h40, 8'haa);
    acc(1'b0, 8'h40, 8'h00);
    v = 8'($random(seed));
    acc(1'b1, 8'h27, v);
    acc(1'b0, 8'h27, v);
    chk(32'(PIN_PICK_O), 32'(v));
    foreach (tab[i])
    begin
      t = tab[i];
      b = {$random(seed), $random(seed)};
      wl = (t[32:31] == 2'b11) ? 32 : 16 + 4 * t[32:31];
      mask = 32'((64'h1 << wl) - 1);
      acc(1'b1, 8'h26, {3'b000, t[30:26]});
      acc(1'b1, 8'h27, t[7:0]);
      acc(1'b1, 8'h28, t[25:18]);
      acc(1'b1, 8'h29, t[17:10]);
      FORMAT_I = t[34:33];
      WORD_LEN_I = t[32:31];
      if (t[23])
        q1.push_back((b[32 * t[0] +: 32] ^ 32'(t[22:18])) & mask);
      if (t[15])
        q2.push_back((b[32 * t[1] +: 32] ^ 32'(t[14:10])) & mask);
      if (t[15])
        last2 = q2[0];
      host.send(t[34:33], wl, int'(t[30:26]), b);
      repeat (4) @(posedge CORE_CLK_I);
      chk(32'(q1.size() + q2.size()), 32'h0000_0000);
      chk(DAC_CH_TWO_SAMPLE_O, last2);
    end
    // a reset in mid-run, with the bit clock standing high, brings back the reset values
    #1;
    RSTN_I = 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    #1;
    RSTN_I = 1'b1;
    chk(32'(PIN_PICK_O), 32'h0000_0000);
    foreach (tab[i])
      acc(1'b0, 8'h26 + 8'(i), i == 3 ? 8'h01 : 8'h00);
    report_and_stop();
  end
endmodule : tb_secondary_serial_rx_slot_map

`default_nettype wire
